// >>> design/rtccs_top.sv
// control, status, flag, debug and calibration logic of the counter
//
// What this block does
// [RULE1] prescaler divides slow clock by two to the control bits 6:3
// [RULE2] control writes take effect two slow ticks later
// [RULE3] software waits for control busy clear before rewriting control
// [RULE4] control bit 7 keeps the counter running in standby sleep
// [RULE5] control bit 2 switches frequency correction on
// [RULE6] control bit 0 enables the counter; all control bits reset zero
// [RULE7] status bit 3 shows compare value still synchronising
// [RULE8] status bit 2 shows wrap limit still synchronising
// [RULE9] status bit 1 shows count value still synchronising
// [RULE10] status bit 0 shows control value still synchronising
// [RULE11] enable bit 1 enables the compare match interrupt
// [RULE12] enable bit 0 enables the wrap interrupt
// [RULE13] flag bit 1 sets when count equals compare
// [RULE14] flag bit 0 sets when count reaches wrap limit and wraps
// [RULE15] writing one clears a flag, zero leaves it
// [RULE16] request stands while a flag and its enable are both set
// [RULE17] one shared byte latch serves all wide registers
// [RULE18] in debug halt the counter stops unless debug run bit is set
// [RULE19] calibration bit 7 picks slower or faster correction
// [RULE20] software uses faster correction only at divide by two or more
// [RULE21] calibration bits 6:0 give corrections per million slow cycles
// [RULE22] corrections only when enabled, spread evenly over the interval
`timescale 1ns/1ps
module rtccs_top #(
  parameter int CORR_INTERVAL = rtccs_pkg::CORR_INTERVAL_PPM
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // slow clock enable and system state
  input  wire logic        slow_tick,
  input  wire logic        standby_sleep,
  input  wire logic        debug_halt,
  // wide value registers outside this block
  input  wire logic        count_write,
  input  wire logic [15:0] count_wdata,
  input  wire logic        wrap_limit_write,
  input  wire logic [15:0] wrap_limit_wdata,
  input  wire logic        compare_write,
  input  wire logic [15:0] compare_wdata,
  input  wire logic        latch_load,
  input  wire logic [7:0]  latch_load_data,
  // results
  output logic      [7:0]  wide_latch,
  output logic      [15:0] count_value,
  output logic             compare_match,
  output logic             wrap_event,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_act;
    logic [7:0]  inten;
    logic [7:0]  flags;
    logic [7:0]  latch;
    logic [7:0]  dbg;
    logic [7:0]  frequency_calibration;
    logic [7:0]  rdata;
    logic [1:0]  ctrl_sync;
    logic [1:0]  cnt_sync;
    logic [1:0]  per_sync;
    logic [1:0]  cmp_sync;
    logic [15:0] count;
    logic [15:0] cnt_hold;
    logic [15:0] per_hold;
    logic [15:0] cmp_hold;
    logic [15:0] wrap_limit;
    logic [15:0] compare;
    logic        cmp_evt;
    logic        wrap_evt;
  } rtccs_top_state_t;

  rtccs_top_state_t s;
  rtccs_top_state_t next_s;
  rtccs_if          pif ();
  logic [7:0]       status;
  logic             run;

  // ==========================================================
  // helpers
  function automatic logic [1:0] sync_step(input logic [1:0] c,
                                           input logic       tick);
    return (tick && c != 2'h0) ? c - 2'h1 : c;
  endfunction

  function automatic logic sync_done(input logic [1:0] c,
                                     input logic       tick);
    return tick && c == 2'h1;
  endfunction

  function automatic logic is_wr(input logic [2:0] ofs);
    return reg_wr && reg_addr == ofs;
  endfunction

  // ==========================================================
  // run gating and prescaler hookup
  assign run = s.ctrl_act[rtccs_pkg::CTRL_EN_BIT] // RULE6
    && (!standby_sleep || s.ctrl_act[rtccs_pkg::CTRL_STBY_BIT]) // RULE4
    && (!debug_halt || s.dbg[rtccs_pkg::DBG_RUN_BIT]); // RULE18

  assign pif.slow_tick = slow_tick;
  assign pif.run       = run;
  assign pif.corr_en   = s.ctrl_act[rtccs_pkg::CTRL_CORR_BIT]; // RULE5
  assign pif.corr_neg  = s.frequency_calibration[rtccs_pkg::CAL_SIGN_BIT]; // RULE19
  assign pif.presc     =
    s.ctrl_act[rtccs_pkg::CTRL_PRESC_LO +: rtccs_pkg::PRESC_W]; // RULE1
  assign pif.corr_err  = s.frequency_calibration[rtccs_pkg::CAL_ERR_W-1:0]; // RULE21

  rtccs_prescaler #(
    .CORR_INTERVAL (CORR_INTERVAL)
  ) u_presc (
    .core_clk (core_clk),
    .rst      (rst),
    .pif      (pif.pre)
  );

  // ==========================================================
  // status view
  always_comb begin
    status = 8'h00;
    status[rtccs_pkg::STAT_CTRL_BIT] = s.ctrl_sync != 2'h0; // RULE10
    status[rtccs_pkg::STAT_CNT_BIT]  = s.cnt_sync != 2'h0; // RULE9
    status[rtccs_pkg::STAT_PER_BIT]  = s.per_sync != 2'h0; // RULE8
    status[rtccs_pkg::STAT_CMP_BIT]  = s.cmp_sync != 2'h0; // RULE7
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.cmp_evt  = 1'b0;
    next_s.wrap_evt = 1'b0;
    next_s.rdata    = 8'h00;

    // slow-domain hand-over: two slow ticks after each control or wide value write
    next_s.ctrl_sync = sync_step(s.ctrl_sync, slow_tick);
    next_s.cnt_sync  = sync_step(s.cnt_sync, slow_tick);
    next_s.per_sync  = sync_step(s.per_sync, slow_tick);
    next_s.cmp_sync  = sync_step(s.cmp_sync, slow_tick);
    if (sync_done(s.ctrl_sync, slow_tick)) begin
      next_s.ctrl_act = s.ctrl_reg; // RULE2
    end
    if (sync_done(s.per_sync, slow_tick)) begin
      next_s.wrap_limit = s.per_hold;
    end
    if (sync_done(s.cmp_sync, slow_tick)) begin
      next_s.compare = s.cmp_hold;
    end

    // counting on the prescaled tick
    if (pif.pre_tick && run) begin
      if (s.count == s.compare) begin
        next_s.cmp_evt = 1'b1;
      end
      if (s.count == s.wrap_limit) begin
        next_s.count    = '0;
        next_s.wrap_evt = 1'b1;
      end else begin
        next_s.count = s.count + 16'h0001;
      end
    end
    // a synchronised count load overrides the increment
    if (sync_done(s.cnt_sync, slow_tick)) begin
      next_s.count = s.cnt_hold;
    end

    // register writes
    if (is_wr(rtccs_pkg::OFS_CTRL)) begin
      // a rewrite while busy restarts the hand-over
      next_s.ctrl_reg  = reg_wdata & rtccs_pkg::CTRL_MASK; // RULE3
      next_s.ctrl_sync = rtccs_pkg::SYNC_TICKS; // RULE10
    end
    if (is_wr(rtccs_pkg::OFS_INTEN)) begin
      next_s.inten = reg_wdata & rtccs_pkg::INTEN_MASK; // RULE11 RULE12
    end
    if (is_wr(rtccs_pkg::OFS_FLAGS)) begin
      next_s.flags = s.flags & ~(reg_wdata & rtccs_pkg::INTEN_MASK); // RULE15
    end
    if (latch_load) begin
      next_s.latch = latch_load_data; // RULE17
    end
    if (is_wr(rtccs_pkg::OFS_LATCH)) begin
      next_s.latch = reg_wdata; // RULE17
    end
    if (is_wr(rtccs_pkg::OFS_DBG)) begin
      next_s.dbg = reg_wdata & rtccs_pkg::DBG_MASK; // RULE18
    end
    if (is_wr(rtccs_pkg::OFS_FREQUENCY_CALIBRATION)) begin
      next_s.frequency_calibration = reg_wdata; // RULE19 RULE21
    end

    // wide value writes start their own hand-over
    if (count_write) begin
      next_s.cnt_hold = count_wdata;
      next_s.cnt_sync = rtccs_pkg::SYNC_TICKS; // RULE9
    end
    if (wrap_limit_write) begin
      next_s.per_hold = wrap_limit_wdata;
      next_s.per_sync = rtccs_pkg::SYNC_TICKS; // RULE8
    end
    if (compare_write) begin
      next_s.cmp_hold = compare_wdata;
      next_s.cmp_sync = rtccs_pkg::SYNC_TICKS; // RULE7
    end

    // a new event beats a clear in the same cycle
    if (next_s.cmp_evt) begin
      next_s.flags[rtccs_pkg::INT_CMP_BIT] = 1'b1; // RULE13
    end
    if (next_s.wrap_evt) begin
      next_s.flags[rtccs_pkg::INT_WRAP_BIT] = 1'b1; // RULE14
    end

    // read data stands only in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        rtccs_pkg::OFS_CTRL:  next_s.rdata = s.ctrl_reg;
        rtccs_pkg::OFS_STAT:  next_s.rdata = status;
        rtccs_pkg::OFS_INTEN: next_s.rdata = s.inten;
        rtccs_pkg::OFS_FLAGS: next_s.rdata = s.flags;
        rtccs_pkg::OFS_LATCH: next_s.rdata = s.latch;
        rtccs_pkg::OFS_DBG:   next_s.rdata = s.dbg;
        rtccs_pkg::OFS_FREQUENCY_CALIBRATION: next_s.rdata = s.frequency_calibration;
        default:              next_s.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s            <= '0;
      s.ctrl_reg   <= rtccs_pkg::CTRL_RST; // RULE6
      s.ctrl_act   <= rtccs_pkg::CTRL_RST;
      s.inten      <= rtccs_pkg::REG_RST;
      s.flags      <= rtccs_pkg::REG_RST;
      s.latch      <= rtccs_pkg::REG_RST;
      s.dbg        <= rtccs_pkg::REG_RST;
      s.frequency_calibration      <= rtccs_pkg::REG_RST;
      s.count      <= rtccs_pkg::COUNT_RST;
      s.per_hold   <= rtccs_pkg::WRAP_RST;
      s.wrap_limit <= rtccs_pkg::WRAP_RST;
      s.cmp_hold   <= rtccs_pkg::CMP_RST;
      s.compare    <= rtccs_pkg::CMP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata     = s.rdata;
  assign wide_latch    = s.latch;
  assign count_value   = s.count;
  assign compare_match = s.cmp_evt;
  assign wrap_event    = s.wrap_evt;
  assign irq = |(s.flags & s.inten & rtccs_pkg::INTEN_MASK); // RULE16

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence ctrl_wr_s;
    reg_wr && reg_addr == rtccs_pkg::OFS_CTRL;
  endsequence

  sequence quiet_s;
    !reg_wr && !slow_tick;
  endsequence

  ctrl_busy_a: assert property (ctrl_wr_s ##1 quiet_s |-> // RULE10
    status[rtccs_pkg::STAT_CTRL_BIT] && s.ctrl_act != s.ctrl_reg
    || s.ctrl_act == s.ctrl_reg)
    else $error("control busy missing after write");
  ctrl_apply_a: assert property ($fell(s.ctrl_sync != 2'h0) // RULE2
    |-> s.ctrl_act == s.ctrl_reg && $past(slow_tick))
    else $error("control applied at the wrong time");
  cmp_busy_a: assert property (compare_write |=> // RULE7
    status[rtccs_pkg::STAT_CMP_BIT])
    else $error("compare busy not raised");
  cnt_busy_a: assert property (count_write |=> // RULE9
    status[rtccs_pkg::STAT_CNT_BIT] && s.cnt_hold == $past(count_wdata))
    else $error("count busy not raised");
  cmp_flag_a: assert property (s.cmp_evt |-> // RULE13
    s.flags[rtccs_pkg::INT_CMP_BIT] && s.count != $past(s.count))
    else $error("compare flag not set on match");
  wrap_flag_a: assert property (s.wrap_evt |-> // RULE14
    s.flags[rtccs_pkg::INT_WRAP_BIT] && s.count == 16'h0000
    || $past(s.cnt_sync) == 2'h1)
    else $error("wrap flag or count wrong on wrap");
  flag_clr_a: assert property (is_wr(rtccs_pkg::OFS_FLAGS) && // RULE15
    reg_wdata[rtccs_pkg::INT_WRAP_BIT] && !next_s.wrap_evt
    |=> !s.flags[rtccs_pkg::INT_WRAP_BIT])
    else $error("write one did not clear the flag");
  irq_hold_a: assert property (s.flags[rtccs_pkg::INT_CMP_BIT] && // RULE16
    s.inten[rtccs_pkg::INT_CMP_BIT] |-> irq)
    else $error("request missing for enabled flag");
  halt_a: assert property (debug_halt && // RULE18
    !s.dbg[rtccs_pkg::DBG_RUN_BIT] && s.cnt_sync == 2'h0
    |=> $stable(s.count))
    else $error("counter moved in debug halt");
  stby_a: assert property (standby_sleep && // RULE4
    !s.ctrl_act[rtccs_pkg::CTRL_STBY_BIT] && s.cnt_sync == 2'h0
    |=> $stable(s.count))
    else $error("counter moved in standby");
endmodule

// >>> include/rtccs_pkg.sv
// constants shared by the counter control block and its prescaler
package rtccs_pkg;
  // ==========================================================
  // register bus
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_CTRL  = 3'h0;
  localparam logic [2:0] OFS_STAT  = 3'h1;
  localparam logic [2:0] OFS_INTEN = 3'h2;
  localparam logic [2:0] OFS_FLAGS = 3'h3;
  localparam logic [2:0] OFS_LATCH = 3'h4;
  localparam logic [2:0] OFS_DBG   = 3'h5;
  localparam logic [2:0] OFS_FREQUENCY_CALIBRATION = 3'h6;
  // ==========================================================
  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CORR_BIT  = 2;
  localparam int CTRL_PRESC_LO  = 3;
  localparam int PRESC_W        = 4;
  localparam int CTRL_STBY_BIT  = 7;
  localparam int STAT_CTRL_BIT  = 0;
  localparam int STAT_CNT_BIT   = 1;
  localparam int STAT_PER_BIT   = 2;
  localparam int STAT_CMP_BIT   = 3;
  localparam int INT_WRAP_BIT   = 0;
  localparam int INT_CMP_BIT    = 1;
  localparam int DBG_RUN_BIT    = 0;
  localparam int CAL_SIGN_BIT   = 7;
  localparam int CAL_ERR_W      = 7;
  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_MASK  = 8'hfd;
  localparam logic [7:0]  INTEN_MASK = 8'h03;
  localparam logic [7:0]  DBG_MASK   = 8'h01;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] WRAP_RST   = 16'hffff;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  // ==========================================================
  // counts
  localparam int CNT_W      = 16;
  localparam int PCNT_W     = 15;
  localparam int ACC_W      = 20;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam int CORR_INTERVAL_PPM = 1000000;
endpackage

// >>> include/rtccs_if.sv
// prescaler hookup between the control block and the prescaler
`timescale 1ns/1ps
interface rtccs_if;
  logic       slow_tick;
  logic       run;
  logic       corr_en;
  logic       corr_neg;
  logic [3:0] presc;
  logic [6:0] corr_err;
  logic       pre_tick;
  modport ctl (output slow_tick, run, corr_en, corr_neg, presc,
               corr_err, input pre_tick);
  modport pre (input slow_tick, run, corr_en, corr_neg, presc,
               corr_err, output pre_tick);
endinterface

// >>> design/rtccs_prescaler.sv
// power-of-two prescaler of the slow tick with ppm correction
`timescale 1ns/1ps
module rtccs_prescaler #(
  parameter int CORR_INTERVAL = rtccs_pkg::CORR_INTERVAL_PPM
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control side
  rtccs_if.pre     pif
);
  typedef struct packed {
    logic [rtccs_pkg::PCNT_W-1:0] pcount;
    logic [rtccs_pkg::ACC_W-1:0]  acc;
    logic                         tick;
  } rtccs_pre_state_t;

  rtccs_pre_state_t s;
  rtccs_pre_state_t next_s;

  localparam logic [rtccs_pkg::ACC_W:0] INTERVAL =
    (rtccs_pkg::ACC_W+1)'(CORR_INTERVAL);

  // ==========================================================
  // next state
  always_comb begin
    logic [rtccs_pkg::ACC_W:0] acc_sum;
    logic [1:0]                step;
    logic [15:0]               sum;
    logic [15:0]               div;
    logic [15:0]               base;
    acc_sum = '0;
    base    = '0;
    step    = 2'h1;
    sum     = '0;
    div     = 16'h0001 << pif.presc; // RULE1
    next_s  = s;
    next_s.tick = 1'b0;
    if (!pif.run) begin
      next_s.pcount = '0;
      next_s.acc    = '0;
    end else if (pif.slow_tick) begin
      // one correction every interval/error slow cycles keeps it even
      if (pif.corr_en && pif.corr_err != 7'h00) begin // RULE22
        acc_sum = {1'b0, s.acc} + (rtccs_pkg::ACC_W+1)'(pif.corr_err);
        if (acc_sum >= INTERVAL) begin // RULE21
          acc_sum = acc_sum - INTERVAL;
          // negative needs divide by two or more to land cleanly
          step = pif.corr_neg ? 2'h2 : 2'h0; // RULE19 RULE20
        end
        next_s.acc = acc_sum[rtccs_pkg::ACC_W-1:0];
      end
      // a count left from a larger divider would otherwise tick at once
      base = ({1'b0, s.pcount} >= div) ? 16'h0000 : {1'b0, s.pcount};
      sum  = base + 16'(step); // RULE1
      if (sum >= div) begin
        next_s.tick   = 1'b1;
        next_s.pcount = rtccs_pkg::PCNT_W'(sum - div);
      end else begin
        next_s.pcount = sum[rtccs_pkg::PCNT_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pif.pre_tick = s.tick;

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  div_one_a: assert property (pif.run && pif.slow_tick && // RULE1
    pif.presc == 4'h0 && !pif.corr_en |=> pif.pre_tick)
    else $error("undivided setting did not pass the tick");
  tick_cause_a: assert property (pif.pre_tick |-> // RULE1
    $past(pif.slow_tick) && $past(pif.run))
    else $error("prescaled tick without a slow tick");
  acc_range_a: assert property ( // RULE21
    s.acc < INTERVAL[rtccs_pkg::ACC_W-1:0])
    else $error("correction accumulator out of range");
endmodule

// >>> tb/rtccs_tick_src.sv
// slow counter clock source, seen by the block as a one-cycle enable
`timescale 1ns/1ps
module rtccs_tick_src #(
  parameter int PERIOD = 6
) (
  // clock
  input  wire logic core_clk,
  // slow clock enable
  output logic      slow_tick
);
  int cnt = 0;

  initial slow_tick = 1'b0;

  // the oscillator runs through reset, as a crystal would
  always @(posedge core_clk) begin
    if (cnt >= PERIOD - 1) begin
      cnt       <= 0;
      slow_tick <= 1'b1;
    end else begin
      cnt       <= cnt + 1;
      slow_tick <= 1'b0;
    end
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the counter control block
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        slow_tick;
  logic        standby_sleep = 1'b0;
  logic        debug_halt = 1'b0;
  logic [2:0]  wide_wr = 3'h0;
  logic [15:0] wide_data = 16'h0000;
  logic        latch_load = 1'b0;
  logic [7:0]  latch_data = 8'h00;
  logic [7:0]  wide_latch;
  logic [15:0] count_value;
  logic        compare_match;
  logic        wrap_event;
  logic        irq;
  int          num_errors = 0;
  int          checks_done = 0;
  int          n_wrap = 0;
  int          n_cmp = 0;
  logic [7:0]  rv;
  logic [15:0] c0;
  logic [15:0] max_cnt;
  logic [2:0]  t_addr [6] = '{3'h2, 3'h5, 3'h6, 3'h4, 3'h1, 3'h7};
  logic [7:0]  t_exp  [6] = '{8'h03, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [15:0] t_wide [3] = '{16'h0000, 16'h0003, 16'h0002};

  always #5 core_clk = ~core_clk;

  rtccs_top #(.CORR_INTERVAL(100)) DUT (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slow_tick(slow_tick),
    .standby_sleep(standby_sleep), .debug_halt(debug_halt),
    .count_write(wide_wr[0]), .count_wdata(wide_data),
    .wrap_limit_write(wide_wr[1]), .wrap_limit_wdata(wide_data),
    .compare_write(wide_wr[2]), .compare_wdata(wide_data),
    .latch_load(latch_load), .latch_load_data(latch_data),
    .wide_latch(wide_latch), .count_value(count_value),
    .compare_match(compare_match), .wrap_event(wrap_event), .irq(irq));

  rtccs_tick_src #(.PERIOD(6)) far (.core_clk(core_clk),
                                    .slow_tick(slow_tick));

  // event pulses stand one cycle; look at them mid-cycle
  always @(negedge core_clk) begin
    if (wrap_event === 1'b1) begin
      n_wrap++;
      chk("wrap to zero", 16'h0000, count_value);
    end
    if (compare_match === 1'b1) begin
      n_cmp++;
      chk("match step", t_wide[2] + 16'h0001, count_value);
    end
  end

  // ==========================================================
  // bus tasks and checks
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // polling busy first keeps control rewrites legal for software
  task automatic wait_idle();
    int n;
    n = 0;
    rd(rtccs_pkg::OFS_STAT, rv);
    while (rv !== 8'h00 && n < 40) begin
      rd(rtccs_pkg::OFS_STAT, rv);
      n++;
    end
    chk("status idle", 8'h00, {8'h00, rv});
  endtask

  task automatic wide(input int sel, input logic [15:0] d);
    @(posedge core_clk);
    wide_data    <= d;
    wide_wr[sel] <= 1'b1;
    @(posedge core_clk);
    wide_wr      <= 3'h0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk iff slow_tick === 1'b1);
      #1;
      if (count_value > max_cnt) max_cnt = count_value;
    end
  endtask

  // phase of prescaler and pipeline make the step count loose by one
  task automatic span(input int n, input logic [15:0] lo,
                      input logic [15:0] hi);
    logic [15:0] d;
    #1;
    c0 = count_value;
    ticks(n);
    repeat (3) @(posedge core_clk);
    #1;
    d = count_value - c0;
    checks_done++;
    if ((d >= lo && d <= hi) !== 1'b1) begin
      num_errors++;
      $display("[FAIL] count steps expected %0d..%0d seen %0d", lo, hi, d);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], rv);
      chk("reset value", 8'h00, {8'h00, rv});
    end
    for (int i = 0; i < 6; i++) begin
      wr(t_addr[i], 8'hff);
      rd(t_addr[i], rv);
      chk("register readback", t_exp[i], rv);
    end
    wr(rtccs_pkg::OFS_INTEN, 8'h00);
    wr(rtccs_pkg::OFS_DBG, 8'h00);
    wr(rtccs_pkg::OFS_FREQUENCY_CALIBRATION, 8'h00);
    wr(rtccs_pkg::OFS_CTRL, 8'hff);
    rd(rtccs_pkg::OFS_CTRL, rv);
    chk("control readback", 8'hfd, rv);
    wait_idle();
    wr(rtccs_pkg::OFS_CTRL, 8'h00);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      wide(i, t_wide[i]);
      rd(rtccs_pkg::OFS_STAT, rv);
      chk("wide sync busy", 16'h0002 << i, rv);
      wait_idle();
    end
    wr(rtccs_pkg::OFS_CTRL, 8'h01);
    rd(rtccs_pkg::OFS_STAT, rv);
    chk("control busy", 8'h01, rv);
    wait_idle();
    max_cnt = 16'h0000;
    n_wrap = 0;
    n_cmp = 0;
    ticks(30);
    chk("count limit", 16'h0003, max_cnt);
    chk("event pulses", 16'h0001, 16'(n_wrap >= 7 && n_cmp >= 7));
    wr(rtccs_pkg::OFS_CTRL, 8'h00);
    wait_idle();
    rd(rtccs_pkg::OFS_FLAGS, rv);
    chk("both flags", 8'h03, rv);
    chk("irq masked", 1'b0, irq);
    wr(rtccs_pkg::OFS_INTEN, 8'h02);
    chk("irq compare", 1'b1, irq);
    wr(rtccs_pkg::OFS_FLAGS, 8'h00);
    rd(rtccs_pkg::OFS_FLAGS, rv);
    chk("zero write", 8'h03, rv);
    wr(rtccs_pkg::OFS_FLAGS, 8'h02);
    chk("irq after clear", 1'b0, irq);
    rd(rtccs_pkg::OFS_FLAGS, rv);
    chk("one cleared", 8'h01, rv);
    wr(rtccs_pkg::OFS_INTEN, 8'h01);
    chk("irq wrap", 1'b1, irq);
    wr(rtccs_pkg::OFS_FLAGS, 8'h01);
    chk("irq wrap clear", 1'b0, irq);
    wide(1, 16'hffff);
    wait_idle();
    for (int c = 0; c < 4; c++) begin
      wr(rtccs_pkg::OFS_CTRL, {1'b0, c[3:0], 3'h1});
      wait_idle();
      span(8 << c, 7, 9);
    end
    wr(rtccs_pkg::OFS_FREQUENCY_CALIBRATION, 8'h0a);
    wr(rtccs_pkg::OFS_CTRL, 8'h01);
    wait_idle();
    span(100, 99, 101);
    wr(rtccs_pkg::OFS_CTRL, 8'h05);
    wait_idle();
    span(100, 89, 91);
    wr(rtccs_pkg::OFS_FREQUENCY_CALIBRATION, 8'h8a);
    wr(rtccs_pkg::OFS_CTRL, 8'h0d);
    wait_idle();
    span(100, 54, 56);
    wr(rtccs_pkg::OFS_CTRL, 8'h01);
    wait_idle();
    @(posedge core_clk);
    standby_sleep <= 1'b1;
    span(20, 0, 1);
    wr(rtccs_pkg::OFS_CTRL, 8'h81);
    wait_idle();
    span(20, 19, 21);
    @(posedge core_clk);
    standby_sleep <= 1'b0;
    debug_halt    <= 1'b1;
    span(20, 0, 1);
    wr(rtccs_pkg::OFS_DBG, 8'h01);
    span(20, 19, 21);
    @(posedge core_clk);
    debug_halt    <= 1'b0;
    @(posedge core_clk);
    latch_data <= 8'h3c;
    latch_load <= 1'b1;
    @(posedge core_clk);
    latch_load <= 1'b0;
    rd(rtccs_pkg::OFS_LATCH, rv);
    chk("latch read", 8'h3c, rv);
    chk("latch port", 8'h3c, wide_latch);
    conclude();
  end

  initial begin
    #400000;
    num_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    conclude();
  end
endmodule
